// File: design/adcdma_pkg.sv
// adcdma_pkg: constants and carrier types for the adc dma capture block
package adcdma_pkg;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned SAMPLE_PERIOD_NS = 5000;
   localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   // shortest sample spacing, rounded up to whole cycles
   localparam int unsigned SAMPLE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] SAMPLE_CNT_LAST = 8'(SAMPLE_CYCLES - 1);
   localparam int unsigned NUM_CAL = 4;
   localparam logic [3:0] CHAN_STOP = 4'hf;
   localparam logic [23:0] PTR_INC = 24'h000001;
   localparam logic [1:0] PTR_LOW = 2'h0;
   localparam logic [1:0] PTR_MID = 2'h1;
   localparam logic [1:0] PTR_PAGE = 2'h2;
   localparam logic [1:0] CAL_OFS_LO = 2'h0;
   localparam logic [1:0] CAL_OFS_HI = 2'h1;
   localparam logic [1:0] CAL_GAIN_LO = 2'h2;
   localparam logic [1:0] CAL_GAIN_HI = 2'h3;
   // control one: bit 7 powers the adc, bits 3:2 nonzero = conversion timing set
   localparam int unsigned C1_PWR_BIT = 7;
   localparam int unsigned C1_TIME_HI = 3;
   localparam int unsigned C1_TIME_LO = 2;
   // control two: bit 7 irq flag, bit 6 dma enable, bit 5 continuous mode, bits 3:0 channel
   localparam int unsigned C2_IRQ_BIT = 7;
   localparam int unsigned C2_DMA_BIT = 6;
   localparam int unsigned C2_CONT_BIT = 5;
   localparam logic [7:0] C2_RESET = 8'h00;
   localparam logic [7:0] C1_RESET = 8'h00;

   typedef struct packed {
      logic valid;
      logic [3:0] chan;
      logic [11:0] value;
   } adcdma_result_s;

   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
      logic busy;
   } adcdma_ext_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_CONV = 3'b010,
      ST_WAIT = 3'b011,
      ST_WRITE = 3'b100
   } adcdma_state_e;
endpackage

// File: design/adcdma_top.sv
// adcdma_top: calibration, result formatting and dma capture to external ram
`timescale 1ns/10ps

// Function
// R1: internal reference stays off until adc or a dac is enabled.
// R2: four calibration registers correct offset and gain of every conversion.
// R3: power-on reset loads calibration registers from factory nonvolatile constants.
// R4: software may overwrite calibration registers after reset.
// R5: each 12-bit result goes to high and low result registers.
// R6: upper four bits of result high carry the channel code.
// R7: at most one sample per 5 us interval; unread results get overwritten.
// R8: setting dma enable in control two starts continuous sampling.
// R9: dma writes every result to external ram without the cpu.
// R10: software prefills each external ram entry with its channel code.
// R11: 24-bit start pointer written low, then middle, then page byte.
// R12: channel code 1111 in an entry ends the dma table.
// R13: dma advances only when timing and trigger mode are configured.
// R14: end of dma table sets irq flag in control two and interrupts.
// R15: result words written back keep the channel code in upper bits.
// R16: during dma the cpu runs but its port 0 and 2 accesses are blocked.
// R17: blocked port accesses complete for software but drive no pin data.
// R18: busy is set during a conversion and cleared when it ends.
// R19: per entry read channel, convert, write tagged result back, increment pointer.
// R20: external accesses use the multiplexed address/data strobes without stalling samples.
module adcdma_top (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_c1_wr,
   input wire logic i_c2_wr,
   input wire logic [7:0] i_cdata,
   input wire logic i_cal_wr,
   input wire logic [1:0] i_cal_sel,
   input wire logic [7:0] i_cal_data,
   input wire logic [7:0] i_nv_cal [adcdma_pkg::NUM_CAL],
   input wire logic i_ptr_wr,
   input wire logic [1:0] i_ptr_sel,
   input wire logic [7:0] i_ptr_data,
   input wire logic i_dac_en,
   input wire logic i_conv_done,
   input wire logic [11:0] i_conv_raw,
   input wire logic i_cpu_port_wr,
   input wire logic [15:0] i_cpu_port_data,
   input wire logic [15:0] i_ext_rdata,
   input wire logic i_ext_ready,
   output logic o_ref_on,
   output logic o_conv_start,
   output logic [3:0] o_conv_chan,
   output logic [7:0] o_adc_control_two,
   output logic [7:0] o_adc_control_three,
   output logic [7:0] o_adc_result_high,
   output logic [7:0] o_adc_result_low,
   output logic o_irq,
   output logic o_port_gate,
   output logic [15:0] o_port_data,
   output logic o_port_oe,
   output adcdma_pkg::adcdma_ext_s o_ext,
   output logic [7:0] o_cal [adcdma_pkg::NUM_CAL]
);
   import adcdma_pkg::*;

   typedef struct packed {
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] cal0, cal1, cal2, cal3;
      logic cal_loaded;
      logic [23:0] ptr;
      logic [7:0] ptr_low_st, ptr_mid_st;
      logic [1:0] ptr_phase;
      adcdma_state_e st;
      logic [7:0] gap_cnt;
      logic gap_ok;
      logic busy;
      logic conv_start;
      logic [3:0] chan;
      logic [7:0] res_h, res_l;
      adcdma_result_s buf0, buf1;
      adcdma_ext_s ext;
      logic [15:0] port_data;
      logic port_oe;
      logic done_s1, done_s2, ready_s1, ready_s2;
      logic [11:0] raw_s1, raw_s2;
      logic [15:0] rd_s1, rd_s2;
      logic ref_on;
   } adcdma_state_s;

   adcdma_state_s s_q, s_d;

   // offset then gain correction; gain is a q1.15 fraction, cal3 holds the integer gain bit
   function automatic logic [11:0] correct(input logic [11:0] raw, input logic [15:0] ofs,
                                           input logic [15:0] gain);
      logic signed [17:0] t;
      logic [29:0] p;
      t = 18'($signed({6'h00, raw})) - 18'($signed({ofs[15], ofs[15], ofs}));
      if (t < 0) begin
         t = 18'h00000;
      end else if (t > 18'sh00fff) begin
         t = 18'sh00fff;
      end
      p = 30'(t[11:0]) * 30'(gain);
      if (p[29:27] != 3'h0 || p[26:15] == 12'hfff && p[14]) begin
         correct = 12'hfff;
      end else begin
         correct = p[26:15];
      end
   endfunction

   logic buf_in_ready;
   logic st_conv_now;

   always_comb begin
      s_d = s_q;
      s_d.conv_start = 1'b0;
      s_d.done_s1 = i_conv_done;
      s_d.done_s2 = s_q.done_s1;
      s_d.ready_s1 = i_ext_ready;
      s_d.ready_s2 = s_q.ready_s1;
      s_d.raw_s1 = i_conv_raw;
      s_d.raw_s2 = s_q.raw_s1;
      s_d.rd_s1 = i_ext_rdata;
      s_d.rd_s2 = s_q.rd_s1;
      buf_in_ready = !s_q.buf1.valid;
      st_conv_now = 1'b0;

      // factory constants loaded once after power-on release [R3]
      if (!s_q.cal_loaded) begin
         s_d.cal0 = i_nv_cal[CAL_OFS_LO];
         s_d.cal1 = i_nv_cal[CAL_OFS_HI];
         s_d.cal2 = i_nv_cal[CAL_GAIN_LO];
         s_d.cal3 = i_nv_cal[CAL_GAIN_HI];
         s_d.cal_loaded = 1'b1;
      end else if (i_cal_wr) begin
         unique case (i_cal_sel) // [R4]
            CAL_OFS_LO: s_d.cal0 = i_cal_data;
            CAL_OFS_HI: s_d.cal1 = i_cal_data;
            CAL_GAIN_LO: s_d.cal2 = i_cal_data;
            CAL_GAIN_HI: s_d.cal3 = i_cal_data;
         endcase
      end

      if (i_c1_wr) begin
         s_d.c1 = i_cdata;
      end
      if (i_c2_wr) begin
         s_d.c2 = i_cdata;
      end
      // registered so the pin comes from a flop, yet tracks the control write edge [R1]
      s_d.ref_on = s_d.c1[C1_PWR_BIT] | i_dac_en;

      // pointer bytes staged until the page byte commits the whole address [R11]
      if (i_ptr_wr) begin
         unique case (i_ptr_sel)
            PTR_LOW: begin
               s_d.ptr_low_st = i_ptr_data;
               s_d.ptr_phase = PTR_MID;
            end
            PTR_MID: begin
               s_d.ptr_mid_st = i_ptr_data;
               if (s_q.ptr_phase == PTR_MID) begin
                  s_d.ptr_phase = PTR_PAGE;
               end
            end
            PTR_PAGE: begin
               if (s_q.ptr_phase == PTR_PAGE) begin
                  s_d.ptr = {i_ptr_data, s_q.ptr_mid_st, s_q.ptr_low_st};
               end
               s_d.ptr_phase = PTR_LOW;
            end
            default: s_d.ptr_phase = PTR_LOW;
         endcase
      end

      // 5 us minimum spacing between conversion starts [R7]
      if (s_q.gap_cnt != 8'h00) begin
         s_d.gap_cnt = s_q.gap_cnt - 8'h01;
      end else begin
         s_d.gap_ok = 1'b1;
      end

      // finished conversion lands in the two-entry buffer
      if (s_q.busy && s_q.done_s2) begin
         s_d.busy = 1'b0; // [R18]
         if (buf_in_ready) begin
            if (!s_q.buf0.valid) begin
               s_d.buf0 = '{valid: 1'b1, chan: s_q.chan,
                  value: correct(s_q.raw_s2, {s_q.cal1, s_q.cal0}, {s_q.cal3, s_q.cal2})}; // [R2]
            end else begin
               s_d.buf1 = '{valid: 1'b1, chan: s_q.chan,
                  value: correct(s_q.raw_s2, {s_q.cal1, s_q.cal0}, {s_q.cal3, s_q.cal2})};
            end
         end
      end

      // drain side: cpu result registers, overwritten if not read in time [R5] [R6] [R7]
      if (s_q.buf0.valid && (!s_q.c2[C2_DMA_BIT] || s_q.st == ST_WAIT)) begin
         s_d.res_h = {s_q.buf0.chan, s_q.buf0.value[11:8]};
         s_d.res_l = s_q.buf0.value[7:0];
         if (s_q.c2[C2_DMA_BIT]) begin
            s_d.ext.wdata = {s_q.buf0.chan, s_q.buf0.value}; // [R15]
            s_d.ext.wr = 1'b1;
            s_d.st = ST_WRITE;
         end
         s_d.buf0 = s_q.buf1;
         s_d.buf1.valid = 1'b0;
      end

      unique case (s_q.st)
         ST_IDLE: begin
            // start only with timing and continuous trigger configured [R8] [R13]
            if (s_q.c2[C2_DMA_BIT] && s_q.c2[C2_CONT_BIT] && s_q.c1[C1_PWR_BIT] &&
                s_q.c1[C1_TIME_HI:C1_TIME_LO] != 2'h0) begin
               s_d.ext.addr = s_q.ptr;
               s_d.ext.rd = 1'b1;
               s_d.ext.busy = 1'b1;
               s_d.st = ST_READ;
            end
         end
         ST_READ: begin
            if (s_q.ready_s2) begin // [R19]
               s_d.ext.rd = 1'b0;
               if (s_q.rd_s2[15:12] == CHAN_STOP) begin
                  s_d.c2[C2_IRQ_BIT] = 1'b1; // [R12] [R14]
                  s_d.c2[C2_DMA_BIT] = 1'b0;
                  s_d.ext.busy = 1'b0;
                  s_d.st = ST_IDLE;
               end else begin
                  s_d.chan = s_q.rd_s2[15:12];
                  s_d.st = ST_CONV;
               end
            end
         end
         ST_CONV: begin
            if (s_q.gap_ok && !s_q.busy && buf_in_ready) begin
               st_conv_now = 1'b1;
               s_d.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
         end
         ST_WRITE: begin
            // ready is a level seen two flops late: let it fall before the next read
            if (s_q.ready_s2 && s_q.ext.wr) begin // [R9]
               s_d.ext.wr = 1'b0;
               s_d.ext.addr = s_q.ext.addr + PTR_INC;
            end else if (!s_q.ready_s2 && !s_q.ext.wr) begin
               s_d.ext.rd = 1'b1;
               s_d.st = ST_READ;
            end
         end
      endcase

      // cpu-driven conversion outside dma, channel from control two
      if (!s_q.c2[C2_DMA_BIT] && s_q.c2[C2_CONT_BIT] && s_q.c1[C1_PWR_BIT] && s_q.gap_ok &&
          !s_q.busy && buf_in_ready) begin
         s_d.chan = s_q.c2[3:0];
         st_conv_now = 1'b1;
      end
      if (st_conv_now) begin
         s_d.conv_start = 1'b1;
         s_d.busy = 1'b1; // [R18]
         s_d.gap_ok = 1'b0;
         s_d.gap_cnt = SAMPLE_CNT_LAST;
      end

      // cpu port writes swallowed while dma owns ports 0 and 2 [R16] [R17]
      s_d.port_oe = s_q.port_oe && !s_q.ext.busy;
      if (i_cpu_port_wr && !s_q.ext.busy) begin
         s_d.port_data = i_cpu_port_data;
         s_d.port_oe = 1'b1;
      end
      // pins carry the dma address/data when dma owns the bus [R20]
      if (s_q.ext.busy) begin
         s_d.port_data = s_q.ext.wr ? s_q.ext.wdata : s_q.ext.addr[15:0];
         s_d.port_oe = s_q.ext.wr || s_q.ext.rd;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.c1 <= C1_RESET;
         s_q.c2 <= C2_RESET;
         s_q.st <= ST_IDLE;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_ref_on = s_q.ref_on;
   assign o_conv_start = s_q.conv_start;
   assign o_conv_chan = s_q.chan;
   assign o_adc_control_two = s_q.c2;
   assign o_adc_control_three = {s_q.busy, 7'h00};
   assign o_adc_result_high = s_q.res_h;
   assign o_adc_result_low = s_q.res_l;
   assign o_irq = s_q.c2[C2_IRQ_BIT]; // [R14]
   assign o_port_gate = s_q.ext.busy;
   assign o_port_data = s_q.port_data;
   assign o_port_oe = s_q.port_oe;
   assign o_ext = s_q.ext;
   assign o_cal[0] = s_q.cal0;
   assign o_cal[1] = s_q.cal1;
   assign o_cal[2] = s_q.cal2;
   assign o_cal[3] = s_q.cal3;
endmodule

// File: testbench/adcdma_top_properties.sv
// assertion checker for the adc dma capture top
`timescale 1ns/10ps
module adcdma_top_properties (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_dac_en,
   input wire logic o_ref_on,
   input wire logic o_conv_start,
   input wire logic [7:0] o_adc_control_two,
   input wire logic [7:0] o_adc_control_three,
   input wire logic o_irq,
   input wire adcdma_pkg::adcdma_ext_s o_ext
);
   import adcdma_pkg::*;
   logic [7:0] gap_q;
   logic [23:0] rda_q;
   // saturating so a long idle never wraps into a false short gap
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_q <= 8'hff;
         rda_q <= 24'h000000;
      end else begin
         gap_q <= o_conv_start ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
         rda_q <= o_ext.rd ? o_ext.addr : rda_q;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_ref_dac: assert property (i_dac_en |-> ##[1:2] o_ref_on) else $error("ref off");
   chk_rsvd_zero: assert property (o_adc_control_three[6:0] == 7'h00) else $error("rsvd set");
   chk_irq_flag: assert property ($rose(o_irq) |-> $past(o_ext.busy)) else $error("irq outside dma");
   chk_sample_gap: assert property (o_conv_start |-> gap_q >= SAMPLE_CNT_LAST) else $error("gap short");
   chk_rw_excl: assert property (!(o_ext.rd && o_ext.wr)) else $error("rd and wr");
   chk_addr_hold: assert property (o_ext.rd && $past(o_ext.rd) |-> $stable(o_ext.addr))
      else $error("addr moved");
   chk_wr_tag: assert property (o_ext.wr |-> o_ext.wdata[15:12] != CHAN_STOP) else $error("stop written");
   chk_wr_addr: assert property (o_ext.wr |-> o_ext.addr == rda_q) else $error("wr addr");
   chk_busy_conv: assert property (o_conv_start |-> ##[0:2] o_adc_control_three[7]) else $error("not busy");
   chk_stop_end: assert property ($rose(o_irq) |-> ##[0:1] !o_adc_control_two[6])
      else $error("dma on");
   cover property (o_conv_start);
   cover property (o_ext.wr);
   cover property ($rose(o_irq));
endmodule

bind adcdma_top adcdma_top_properties adcdma_top_properties_inst (.i_clk, .i_rst, .i_dac_en, .o_ref_on,
   .o_conv_start, .o_adc_control_two, .o_adc_control_three, .o_irq, .o_ext);

// File: testbench/adcdma_sram_model.sv
// external static ram model answering the dma bus
`timescale 1ns/10ps
module adcdma_sram_model #(
   parameter int LAT = 2
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire adcdma_pkg::adcdma_ext_s i_ext,
   output logic [15:0] o_rdata,
   output logic o_ready
);
   import adcdma_pkg::*;
   logic [15:0] mem_q [32];
   int cnt;
   initial begin
      foreach (mem_q[k]) mem_q[k] = 16'hf000;
      mem_q[16] = 16'h3000;
      mem_q[17] = 16'h5000;
   end
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 0;
         o_ready <= 1'b0;
         o_rdata <= 16'h0000;
      end else if (i_ext.rd || i_ext.wr) begin
         cnt <= cnt + 1;
         if (cnt >= LAT) begin
            o_ready <= 1'b1;
            o_rdata <= mem_q[i_ext.addr[4:0]];
            if (i_ext.wr)
               mem_q[i_ext.addr[4:0]] <= i_ext.wdata;
         end
      end else begin
         cnt <= 0;
         o_ready <= 1'b0;
         // released bus keeps toggling so stale data is never mistaken
         o_rdata <= ~o_rdata;
      end
   end
endmodule

// File: testbench/adcdma_top_tb_top.sv
// testbench for the adc dma capture top
`timescale 1ns/10ps
module adcdma_top_tb_top;
   import adcdma_pkg::*;
   logic i_clk, i_rst, i_ce, i_c1_wr, i_c2_wr, i_cal_wr, i_ptr_wr, i_dac_en, i_conv_done;
   logic i_cpu_port_wr, i_ext_ready, o_ref_on, o_conv_start, o_irq, o_port_gate, o_port_oe;
   logic [1:0] i_cal_sel, i_ptr_sel;
   logic [7:0] i_cdata, i_cal_data, i_ptr_data, o_adc_control_two, o_adc_control_three;
   logic [7:0] o_adc_result_high, o_adc_result_low;
   logic [3:0] o_conv_chan;
   logic [11:0] i_conv_raw;
   logic [15:0] i_cpu_port_data, i_ext_rdata, o_port_data;
   logic [7:0] i_nv_cal [NUM_CAL];
   logic [7:0] o_cal [NUM_CAL];
   adcdma_ext_s o_ext;
   int n_mismatch = 0;
   int checked = 0;
   int k;
   adcdma_top adcdma_top_inst (.i_clk, .i_rst, .i_ce, .i_c1_wr, .i_c2_wr, .i_cdata, .i_cal_wr, .i_cal_sel,
      .i_cal_data, .i_nv_cal, .i_ptr_wr, .i_ptr_sel, .i_ptr_data, .i_dac_en, .i_conv_done, .i_conv_raw,
      .i_cpu_port_wr, .i_cpu_port_data, .i_ext_rdata, .i_ext_ready, .o_ref_on, .o_conv_start, .o_conv_chan,
      .o_adc_control_two, .o_adc_control_three, .o_adc_result_high, .o_adc_result_low, .o_irq,
      .o_port_gate, .o_port_data, .o_port_oe, .o_ext, .o_cal);
   adcdma_sram_model #(.LAT(3)) adcdma_sram_model_inst (.i_clk, .i_rst, .i_ext(o_ext),
      .o_rdata(i_ext_rdata), .o_ready(i_ext_ready));
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // r: 0 control one, 1 control two, 2 calibration, 3 pointer, 4 cpu port
   task automatic put(input int r, input logic [1:0] s, input logic [7:0] d);
      @(negedge i_clk);
      {i_cdata, i_cal_data, i_ptr_data} = {3{d}};
      {i_cal_sel, i_ptr_sel} = {2{s}};
      {i_c1_wr, i_c2_wr, i_cal_wr, i_ptr_wr, i_cpu_port_wr} = 5'h10 >> r;
      @(negedge i_clk);
      {i_c1_wr, i_c2_wr, i_cal_wr, i_ptr_wr, i_cpu_port_wr} = 5'h00;
   endtask
   function automatic logic sig(input int w);
      return w == 0 ? o_ext.rd : (w == 1 ? o_port_gate : o_irq);
   endfunction
   task automatic till(input int w);
      for (k = 0; k < 3000 && sig(w) !== 1'b1; k++)
         @(negedge i_clk);
      if (k == 3000) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // converter stand-in: raw value carries the channel so results are traceable
   initial begin
      i_conv_done = 1'b0;
      i_conv_raw = 12'h000;
      forever begin
         @(negedge i_clk);
         if (o_conv_start === 1'b1) begin
            i_conv_raw = {8'h0a, o_conv_chan};
            repeat (10) @(negedge i_clk);
            i_conv_done = 1'b1;
            repeat (3) @(negedge i_clk);
            i_conv_done = 1'b0;
            i_conv_raw = ~i_conv_raw;
         end
      end
   end
   initial begin
      i_rst = 1'b1;
      i_ce = 1'b1;
      i_dac_en = 1'b0;
      i_cpu_port_data = 16'hbeef;
      {i_c1_wr, i_c2_wr, i_cal_wr, i_ptr_wr, i_cpu_port_wr} = 5'h00;
      {i_cdata, i_cal_data, i_ptr_data, i_cal_sel, i_ptr_sel} = 28'h0000000;
      i_nv_cal = '{8'h12, 8'h00, 8'h00, 8'h80};
      repeat (5) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (2) @(negedge i_clk);
      for (k = 0; k < NUM_CAL; k++)
         check("cal", o_cal[k], i_nv_cal[k]);
      check("ref", o_ref_on, 1'b0);
      check("busy", o_adc_control_three, 8'h00);
      $display("test reset done");
      put(2, CAL_OFS_LO, 8'h00);
      put(3, PTR_LOW, 8'h10);
      put(3, PTR_MID, 8'h00);
      put(3, PTR_PAGE, 8'h00);
      put(3, PTR_PAGE, 8'h55);
      check("ofs", o_cal[0], 8'h00);
      put(1, 2'h0, 8'h60);
      for (k = 0; k < 20; k++) begin
         @(negedge i_clk);
         check("early rd", o_ext.rd, 1'b0);
      end
      $display("test setup done");
      put(0, 2'h0, 8'h84);
      check("ref", o_ref_on, 1'b1);
      till(0);
      check("start", o_ext.addr, 24'h000010);
      till(1);
      put(4, 2'h0, 8'h00);
      check("blocked", o_port_oe === 1'b1 && o_port_data === 16'hbeef, 1'b0);
      till(2);
      @(negedge i_clk);
      check("e0", adcdma_sram_model_inst.mem_q[16], 16'h30a3);
      check("e1", adcdma_sram_model_inst.mem_q[17], 16'h50a5);
      check("stop", adcdma_sram_model_inst.mem_q[18], 16'hf000);
      check("hi", o_adc_result_high, 8'h50);
      check("lo", o_adc_result_low, 8'ha5);
      check("c2", o_adc_control_two[7:6], 2'h2);
      put(4, 2'h0, 8'h00);
      check("port", {o_port_oe, o_port_data}, {1'b1, 16'hbeef});
      put(1, 2'h0, 8'h00);
      check("irq", o_irq, 1'b0);
      put(0, 2'h0, 8'h00);
      check("ref off", o_ref_on, 1'b0);
      i_dac_en = 1'b1;
      repeat (3) @(negedge i_clk);
      check("ref dac", o_ref_on, 1'b1);
      $display("test dma done");
      finish_test();
   end
endmodule
